// ===== src/sip_irq_ctrl.sv
// Behaviour
// R01 - Control bit 0 enables the 32-bit timer output as interrupt source.
// R02 - Control bit 1 enables the 16-bit counter output as interrupt source.
// R03 - Control bit 2 enables external request ORed with end-of-conversion.
// R04 - Control bits 3 to 6 have no effect on interrupt behaviour.
// R05 - Writing control bit 7 set re-arms this card only.
// R06 - Power-on reset clears the control register, disabling all sources.
// R07 - Status bits 0 to 2 return enable bits; bit 3 reads zero.
// R08 - Status bit 4 shows live 32-bit timer output level.
// R09 - Status bit 5 shows live 16-bit counter output level.
// R10 - Status bit 6 shows external request ORed with converter interrupt.
// R11 - Each source is ANDed with its own enable bit.
// R12 - Enabled sources are ORed into one card trigger.
// R13 - Trigger drives the shared line low for exactly two clocks.
// R14 - Outside the pulse the line driver floats.
// R15 - Any low on the shared line disarms this card.
// R16 - Re-arm starts on local re-arm OR global clear.
// R17 - Local re-arm only when card-select address bits match this card.
// R18 - Write to 02F3 plus level re-arms globally; data ignored.
// R19 - While disarmed no pulse; pulsing resumes only after re-arm.
`timescale 1ns/100ps
module sip_irq_ctrl (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [15:0] io_addr,
    input  wire logic [7:0]  io_wdata,
    input  wire logic        io_wr_n,
    input  wire logic        io_rd_n,
    output logic      [7:0]  io_rdata,
    output logic             io_rdata_oe,
    input  wire logic [1:0]  card_number,
    input  wire logic [2:0]  level_select_switch,
    input  wire logic        wide_timer_out,
    input  wire logic        counter_out,
    input  wire logic        ext_irq_n,
    input  wire logic        adc_eoc,
    input  wire logic        irq_line_in,
    output logic             irq_line_out,
    output logic             irq_line_oe
);
    logic              rst_meta_r;
    logic              rst_n;

    // Power-on reset released through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    logic [15:0]       addr_s;
    logic [7:0]        wdata_s;
    logic [1:0]        strb_s;
    logic [4:0]        sw_s;
    logic [3:0]        src_s;
    logic              line_s;

    sip_sync #(.W(16), .RST_V(16'h0000)) u_sync_addr (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (io_addr),
        .q     (addr_s)
    );

    sip_sync #(.W(8), .RST_V(16'h0000)) u_sync_data (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (io_wdata),
        .q     (wdata_s)
    );

    // Strobes idle high
    sip_sync #(.W(2), .RST_V(16'h0003)) u_sync_strb (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({io_rd_n, io_wr_n}),
        .q     (strb_s)
    );

    sip_sync #(.W(5), .RST_V(16'h0000)) u_sync_sw (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({level_select_switch, card_number}),
        .q     (sw_s)
    );

    // External request idles high
    sip_sync #(.W(4), .RST_V(16'h0004)) u_sync_src (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({adc_eoc, ext_irq_n, counter_out, wide_timer_out}),
        .q     (src_s)
    );

    // Shared line is pulled up when nobody drives it
    sip_sync #(.W(1), .RST_V(16'h0001)) u_sync_line (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (irq_line_in),
        .q     (line_s)
    );

    logic              wr_n_d_r;
    logic              wr_fall;
    logic              rd_act;
    logic [1:0]        card_s;
    logic [2:0]        level_s;
    logic              card_hit;
    logic              glob_hit;
    logic              ctl_wr;
    logic              loc_rearm;
    logic              glob_rearm;
    logic              rearm;

    assign card_s  = sw_s[1:0];
    assign level_s = sw_s[4:2];

    localparam int PAT_MSB  = sip_pkg::PAT_MSB;
    localparam int PAT_LSB  = sip_pkg::PAT_LSB;
    localparam int CARD_MSB = sip_pkg::CARD_MSB;
    localparam int CARD_LSB = sip_pkg::CARD_LSB;
    localparam int REG_MSB  = sip_pkg::REG_MSB;
    localparam int REG_LSB  = sip_pkg::REG_LSB;

    // One write per strobe, taken on its falling edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_n_d_r <= 1'b1;
        end else begin
            wr_n_d_r <= strb_s[0];
        end
    end

    assign wr_fall = wr_n_d_r && !strb_s[0];
    assign rd_act  = !strb_s[1];

    assign card_hit = (addr_s[PAT_MSB:PAT_LSB] == sip_pkg::CARD_PATTERN)
                   && (addr_s[CARD_MSB:CARD_LSB] == card_s)           // R17
                   && (addr_s[REG_MSB:REG_LSB] == sip_pkg::REG_SEL_IRQ)
                   && !addr_s[0];

    // Out-of-range switch setting never matches
    assign glob_hit = (level_s <= sip_pkg::LEVEL_MAX)
                   && (addr_s == sip_pkg::GLOBAL_BASE + {13'h0000, level_s}); // R18

    assign ctl_wr     = wr_fall && card_hit;
    assign loc_rearm  = ctl_wr && wdata_s[sip_pkg::CTL_REARM];        // R05
    assign glob_rearm = wr_fall && glob_hit;                          // R18
    assign rearm      = loc_rearm || glob_rearm;                      // R16

    logic [2:0]        en_r;
    logic              wide_timer_irq_enable;
    logic              counter_irq_enable;
    logic              ext_irq_enable;

    // Bits 3 to 6 are not stored, so they cannot steer anything
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_r <= sip_pkg::CTL_RESET;                               // R06
        end else if (ctl_wr) begin
            en_r <= wdata_s[2:0];                                     // R04
        end
    end

    assign wide_timer_irq_enable = en_r[sip_pkg::CTL_TMR_EN];
    assign counter_irq_enable    = en_r[sip_pkg::CTL_CNT_EN];
    assign ext_irq_enable        = en_r[sip_pkg::CTL_EXT_EN];

    logic              wide_timer_source_state;
    logic              counter_source_state;
    logic              ext_source_state;
    logic              trigger;
    logic [7:0]        status;

    assign wide_timer_source_state = src_s[0];                        // R08
    assign counter_source_state    = src_s[1];                        // R09
    assign ext_source_state        = !src_s[2] || src_s[3];           // R10

    assign trigger = (wide_timer_source_state && wide_timer_irq_enable)  // R01 R11
                  || (counter_source_state && counter_irq_enable)        // R02 R11
                  || (ext_source_state && ext_irq_enable);               // R03 R12

    always_comb begin
        status                   = sip_pkg::STA_IDLE;
        status[2:0]              = en_r;                              // R07
        status[sip_pkg::STA_TMR] = wide_timer_source_state;
        status[sip_pkg::STA_CNT] = counter_source_state;
        status[sip_pkg::STA_EXT] = ext_source_state;
    end

    // Read data driven only while our own register is addressed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_rdata    <= sip_pkg::STA_IDLE;
            io_rdata_oe <= 1'b0;
        end else begin
            io_rdata    <= (rd_act && card_hit) ? status : sip_pkg::STA_IDLE;
            io_rdata_oe <= rd_act && card_hit;
        end
    end

    sip_pkg::sip_state_t state_r;
    sip_pkg::sip_state_t state_nxt;
    logic [1:0]          cnt_r;

    // Disarm from the line wins over a re-arm in the same cycle,
    // so a pulse from another card is never missed.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sip_pkg::SIP_ARMED: begin
                if (trigger) begin
                    state_nxt = sip_pkg::SIP_PULSE;                   // R13
                end else if (!line_s) begin
                    state_nxt = sip_pkg::SIP_DISARMED;                // R15
                end
            end
            sip_pkg::SIP_PULSE: begin
                if (cnt_r == sip_pkg::PULSE_LAST) begin
                    state_nxt = sip_pkg::SIP_DISARMED;                // R15
                end
            end
            sip_pkg::SIP_DISARMED: begin
                if (rearm && line_s) begin
                    state_nxt = sip_pkg::SIP_ARMED;                   // R16 R19
                end
            end
            default: begin
                state_nxt = sip_pkg::SIP_DISARMED;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= sip_pkg::SIP_ARMED;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 2'h0;
        end else if (state_r == sip_pkg::SIP_PULSE) begin
            cnt_r <= cnt_r + 2'h1;
        end else begin
            cnt_r <= 2'h0;
        end
    end

    // Driver enabled only for the pulse, floating otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_line_oe <= 1'b0;
        end else begin
            irq_line_oe <= (state_nxt == sip_pkg::SIP_PULSE);         // R13 R14
        end
    end

    // Data pin held low: only the enable moves
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_line_out <= 1'b0;
        end else begin
            irq_line_out <= 1'b0;                                     // R13
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_pulse;
        irq_line_oe [*2] ##1 !irq_line_oe;
    endsequence

    sequence s_fire;
        state_r == sip_pkg::SIP_ARMED && trigger;
    endsequence

    pulse_width_a: assert property ($rose(irq_line_oe) |-> s_pulse) // R13
        else $error("request pulse not two clocks");

    drive_low_a: assert property (irq_line_oe |-> !irq_line_out) // R14
        else $error("driver enabled while not low");

    fire_trig_a: assert property (s_fire |=> irq_line_oe ##1 irq_line_oe) // R12
        else $error("armed trigger gave no pulse");

    no_fire_a: assert property ($rose(irq_line_oe) |-> $past(state_r) == sip_pkg::SIP_ARMED) // R19
        else $error("pulse while disarmed");

    line_disarm_a: assert property (state_r == sip_pkg::SIP_ARMED && !trigger && !line_s
                                    |=> state_r == sip_pkg::SIP_DISARMED) // R15
        else $error("line low did not disarm");

    low_hold_a: assert property (state_r == sip_pkg::SIP_DISARMED && !line_s
                                 |=> state_r == sip_pkg::SIP_DISARMED) // R15
        else $error("re-arm while line low");

    pulse_end_a: assert property ($fell(irq_line_oe) |-> state_r == sip_pkg::SIP_DISARMED) // R15
        else $error("card not disarmed after pulse");

    rearm_arm_a: assert property (state_r == sip_pkg::SIP_DISARMED && rearm && line_s
                                  |=> state_r == sip_pkg::SIP_ARMED) // R16
        else $error("re-arm ignored");

    stay_off_a: assert property (state_r == sip_pkg::SIP_DISARMED && !rearm
                                 |=> !irq_line_oe) // R19
        else $error("disarmed card drove line");

    local_rearm_a: assert property (state_r == sip_pkg::SIP_DISARMED && ctl_wr
                                    && wdata_s[sip_pkg::CTL_REARM] && line_s
                                    |=> state_r == sip_pkg::SIP_ARMED) // R05
        else $error("local re-arm ignored");

    out_low_a: assert property (!irq_line_out) // R13
        else $error("line data not held low");

    ctl_write_a: assert property (ctl_wr |=> en_r == $past(wdata_s[2:0])) // R01
        else $error("enable bits not written");

    status_read_a: assert property (rd_act && card_hit
                                    |=> io_rdata_oe && io_rdata[7] == 1'b0
                                    && io_rdata[3] == 1'b0
                                    && io_rdata[2:0] == $past(en_r)) // R07
        else $error("status read wrong");

    src_status_a: assert property (rd_act && card_hit
                                   |=> io_rdata[6:4] == $past(status[6:4])) // R10
        else $error("source status wrong");

    en_hold_a: assert property (!ctl_wr |=> $stable(en_r)) // R04
        else $error("enable bits changed without write");

    foreign_wr_a: assert property (wr_fall && !card_hit |=> $stable(en_r)) // R17
        else $error("enable bits written by another card");

    rd_idle_a: assert property (!(rd_act && card_hit)
                                |=> !io_rdata_oe && io_rdata == sip_pkg::STA_IDLE) // R17
        else $error("read data driven while not addressed");

endmodule

// ===== include/sip_pkg.sv
package sip_pkg;

    // Host I/O address decode
    localparam logic [3:0]  REG_SEL_IRQ     = 4'hD;
    localparam logic [8:0]  CARD_PATTERN    = 9'h171;
    localparam int          CARD_LSB        = 10;
    localparam int          CARD_MSB        = 11;
    localparam int          REG_LSB         = 12;
    localparam int          REG_MSB         = 15;
    localparam int          PAT_LSB         = 1;
    localparam int          PAT_MSB         = 9;
    localparam logic [15:0] GLOBAL_BASE     = 16'h02F3;
    localparam logic [2:0]  LEVEL_MAX       = 3'h4;

    // Control register fields
    localparam int          CTL_TMR_EN      = 0;
    localparam int          CTL_CNT_EN      = 1;
    localparam int          CTL_EXT_EN      = 2;
    localparam int          CTL_REARM       = 7;
    localparam logic [2:0]  CTL_RESET       = 3'h0;

    // Status register fields
    localparam int          STA_TMR         = 4;
    localparam int          STA_CNT         = 5;
    localparam int          STA_EXT         = 6;
    localparam logic [7:0]  STA_IDLE        = 8'h00;

    // Request pulse timing, in system clocks
    localparam int          PULSE_CYCLES    = 2;
    localparam logic [1:0]  PULSE_LAST      = 2'(PULSE_CYCLES - 1);

    typedef enum logic [1:0] {
        SIP_ARMED    = 2'b00,
        SIP_PULSE    = 2'b01,
        SIP_DISARMED = 2'b10
    } sip_state_t;

endpackage

// ===== src/sip_sync.sv
`timescale 1ns/100ps
module sip_sync #(
    parameter int          W     = 1,
    parameter logic [15:0] RST_V = 16'h0000
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_V[W-1:0];
            q      <= RST_V[W-1:0];
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// ===== testbench/sip_host_model.sv
`timescale 1ns/100ps
module sip_host_model (
    input  wire logic clk,
    input  wire logic irq_line_out,
    input  wire logic irq_line_oe,
    input  wire logic other_drive,
    output logic      irq_line_in,
    output int        pulses,
    output int        last_width
);
    int run;

    // Pull-up holds the shared line high unless some card drives it low
    assign irq_line_in = ((irq_line_oe && !irq_line_out) || other_drive) ? 1'b0 : 1'b1;

    initial begin
        pulses = 0;
        last_width = 0;
        run = 0;
    end

    // Host side counts each low request from the card and its length in clocks
    always @(posedge clk) begin
        if (irq_line_oe === 1'b1 && irq_line_out === 1'b0) begin
            run <= run + 1;
        end else if (run != 0) begin
            pulses <= pulses + 1;
            last_width <= run;
            run <= 0;
        end
    end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic [7:0]  io_wdata = 8'h00;
    logic        io_wr_n = 1'b1;
    logic        io_rd_n = 1'b1;
    logic [7:0]  io_rdata;
    logic        io_rdata_oe;
    logic [1:0]  card_number = 2'h0;
    logic [2:0]  level_select_switch = 3'h0;
    logic        wide_timer_out = 1'b0;
    logic        counter_out = 1'b0;
    logic        ext_irq_n = 1'b1;
    logic        adc_eoc = 1'b0;
    logic        irq_line_in;
    logic        irq_line_out;
    logic        irq_line_oe;
    logic        other_drive = 1'b0;
    logic        oe_q = 1'b0;
    logic [15:0] reg_addr;
    logic [7:0]  exp_q[$];
    int          pulses;
    int          last_width;
    int          exp_pulses = 0;
    int          failures = 0;
    int          comparisons = 0;

    always #12.5 clk = ~clk;

    sip_irq_ctrl dut (.clk(clk), .arst_n(arst_n), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_wr_n(io_wr_n), .io_rd_n(io_rd_n), .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe),
        .card_number(card_number), .level_select_switch(level_select_switch),
        .wide_timer_out(wide_timer_out), .counter_out(counter_out), .ext_irq_n(ext_irq_n),
        .adc_eoc(adc_eoc), .irq_line_in(irq_line_in), .irq_line_out(irq_line_out),
        .irq_line_oe(irq_line_oe));

    sip_host_model host (.clk(clk), .irq_line_out(irq_line_out), .irq_line_oe(irq_line_oe),
        .other_drive(other_drive), .irq_line_in(irq_line_in), .pulses(pulses),
        .last_width(last_width));

    task automatic summarize;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Strobe held well past the two-flop input sync so the write is seen once
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr_n = 1'b0;
        cyc(6);
        io_wr_n = 1'b1;
        cyc(6);
    endtask

    task automatic rd(input logic [7:0] exp);
        int n;
        io_addr = reg_addr;
        exp_q.push_back(exp);
        io_rd_n = 1'b0;
        n = 0;
        while (io_rdata_oe !== 1'b1 && n < 10) begin
            cyc(1);
            n++;
        end
        chk({7'h00, io_rdata_oe}, 8'h01);
        cyc(2);
        io_rd_n = 1'b1;
        cyc(6);
    endtask

    // Foreign card or high byte: nothing may be driven
    task automatic rd_none(input logic [15:0] a);
        io_addr = a;
        io_rd_n = 1'b0;
        cyc(6);
        chk({7'h00, io_rdata_oe}, 8'h00);
        io_rd_n = 1'b1;
        cyc(6);
    endtask

    task automatic pulse_chk(input int add);
        int n;
        exp_pulses += add;
        n = 0;
        while (pulses < exp_pulses && n < 30) begin
            cyc(1);
            n++;
        end
        cyc(10);
        chk(8'(pulses), 8'(exp_pulses));
        if (add != 0) chk(8'(last_width), 8'(sip_pkg::PULSE_CYCLES));
    endtask

    // External source goes true through either input or both
    task automatic src(input logic [2:0] s);
        int r;
        r = $urandom % 3;
        wide_timer_out = s[0];
        counter_out = s[1];
        ext_irq_n = !(s[2] && r != 1);
        adc_eoc = s[2] && r != 0;
    endtask

    // Read monitor pairs each fresh read answer with the oldest expectation
    always @(negedge clk) begin
        if (io_rdata_oe === 1'b1 && oe_q !== 1'b1) begin
            if (exp_q.size() != 0) chk(io_rdata, exp_q.pop_front());
            else chk({7'h00, io_rdata_oe}, 8'h00);
        end
        oe_q <= io_rdata_oe;
    end

    initial begin
        #(25 * 40000);
        failures++;
        summarize();
    end

    initial begin
        void'($urandom(98755));
        card_number = 2'($urandom % 4);
        level_select_switch = 3'($urandom % 5);
        reg_addr = {sip_pkg::REG_SEL_IRQ, card_number, sip_pkg::CARD_PATTERN, 1'b0};
        cyc(10);
        arst_n = 1'b1;
        cyc(8);
        rd(8'h00);
        rd_none(reg_addr | 16'h0001);
        rd_none(reg_addr ^ 16'h0400);
        $display("test reset done");
        wr(reg_addr, 8'h78);
        src(3'h7);
        rd(8'h70);
        pulse_chk(0);
        $display("test unused bits done");
        for (int i = 0; i < 8; i++) begin
            src(3'(i));
            cyc(4);
            rd({1'b0, 3'(i), 4'h0});
        end
        pulse_chk(0);
        $display("test live status done");
        for (int k = 0; k < 3; k++) begin
            src(3'h0);
            wr(reg_addr, 8'h80);
            wr(reg_addr, 8'(1 << k));
            src(3'(7 ^ (1 << k)));
            pulse_chk(0);
            src(3'(1 << k));
            pulse_chk(1);
            rd({1'b0, 3'(1 << k), 1'b0, 3'(1 << k)});
            pulse_chk(0);
            wr(reg_addr, 8'(8'h80 | (1 << k)));
            pulse_chk(1);
        end
        $display("test sources done");
        wr(reg_addr ^ 16'h0400, 8'h84);
        wr(reg_addr ^ 16'h0800, 8'h84);
        pulse_chk(0);
        wr(sip_pkg::GLOBAL_BASE + 16'((level_select_switch + 1) % 5), 8'($urandom));
        pulse_chk(0);
        wr(sip_pkg::GLOBAL_BASE + 16'(level_select_switch), 8'($urandom));
        pulse_chk(1);
        $display("test re-arm decode done");
        src(3'h0);
        wr(reg_addr, 8'h87);
        pulse_chk(0);
        other_drive = 1'b1;
        cyc(2);
        other_drive = 1'b0;
        cyc(4);
        src(3'h1);
        pulse_chk(0);
        wr(sip_pkg::GLOBAL_BASE + 16'(level_select_switch), 8'($urandom));
        pulse_chk(1);
        $display("test shared line done");
        arst_n = 1'b0;
        cyc(3);
        arst_n = 1'b1;
        cyc(8);
        rd(8'h10);
        pulse_chk(0);
        $display("test second reset done");
        summarize();
    end
endmodule
